// *** verilog/spm_pkg.sv ***
// Purpose: constants for the port power management and MSI capability bank
// Assumes: 32-bit configuration words, byte address in cfg_addr
// Notes: loadable defaults travel as one packed vector, layout below
package spm_pkg;
    // register byte addresses
    localparam logic [7:0] SPM_OFS_PM_CAP = 8'h40;
    localparam logic [7:0] SPM_OFS_PM_CSR = 8'h44;
    localparam logic [7:0] SPM_OFS_MSI_CAP = 8'h4C;
    localparam int SPM_ADDR_W = 8;
    // capability header constants
    localparam logic [7:0] SPM_PM_CAP_ID = 8'h01;
    localparam logic [7:0] SPM_NEXT_UP = 8'h5C;
    localparam logic [7:0] SPM_NEXT_DN = 8'h4C;
    localparam logic [2:0] SPM_PM_REV = 3'h3;
    localparam logic [7:0] SPM_MSI_CAP_ID = 8'h05;
    localparam logic [7:0] SPM_MSI_NEXT = 8'h64;
    localparam logic [2:0] SPM_MSI_MMC = 3'h0;
    localparam logic SPM_MSI_64BIT = 1'b1;
    // loadable default vector layout
    localparam int SPM_DFLT_W = 20;
    localparam int SPM_DF_DSI = 0;
    localparam int SPM_DF_AUX_LO = 1;
    localparam int SPM_DF_AUX_HI = 3;
    localparam int SPM_DF_D1 = 4;
    localparam int SPM_DF_D2 = 5;
    localparam int SPM_DF_PMES_LO = 6;
    localparam int SPM_DF_PMES_HI = 10;
    localparam int SPM_DF_NSR = 11;
    localparam int SPM_DF_DATA_LO = 12;
    localparam int SPM_DF_DATA_HI = 19;
    // dsi 0, aux 111b, d1 1, d2 1, pme 1_1111b, nsr 1, data 00h
    localparam logic [SPM_DFLT_W-1:0] SPM_DFLT_RST = 20'h00FFE;
    // write field positions in the control words
    localparam int SPM_PS_LO = 0;
    localparam int SPM_PS_HI = 1;
    localparam int SPM_PME_EN = 8;
    localparam int SPM_DSEL_LO = 9;
    localparam int SPM_DSEL_HI = 12;
    localparam int SPM_MSI_EN = 16;
    localparam int SPM_MME_LO = 20;
    localparam int SPM_MME_HI = 22;
    // control reset values
    localparam logic [3:0] SPM_DSEL_RST = 4'h0;
    localparam logic [2:0] SPM_MME_RST = 3'h0;
    localparam logic [1:0] SPM_DSCALE = 2'h0;
    localparam logic [1:0] SPM_ADDR_LSB_ZERO = 2'h0;
    // device power states
    typedef enum logic [1:0] {
        SPM_D0 = 2'b00,
        SPM_D1 = 2'b01,
        SPM_D2 = 2'b10,
        SPM_D3HOT = 2'b11
    } spm_dstate_e;
endpackage : spm_pkg

// *** verilog/spm_dflt_hold.sv ***
// Purpose: holds loadable defaults of the read-only capability fields
// Assumes: load strobe comes from the serial bus or EEPROM loader
// Notes: host configuration writes never reach this holder
`timescale 1ns/10ps
module spm_dflt_hold (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [spm_pkg::SPM_DFLT_W-1:0] value,
    output logic [spm_pkg::SPM_DFLT_W-1:0] dflt_q
);
    import spm_pkg::*;

    // reset to documented defaults, replace on loader strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dflt_q <= SPM_DFLT_RST;
        end else if (load) begin
            dflt_q <= value;
        end
    end
endmodule : spm_dflt_hold

// *** verilog/spm_cap_regs.sv ***
// Purpose: power management and MSI capability words of one switch port
// Assumes: one config access per request, answered on the next edge
// Notes: upstream ports have no MSI structure, its word reads zero
`timescale 1ns/10ps
module spm_cap_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic port_is_upstream,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [spm_pkg::SPM_ADDR_W-1:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic dflt_load,
    input wire logic [spm_pkg::SPM_DFLT_W-1:0] dflt_value,
    output logic [1:0] power_state,
    output logic pme_enable,
    output logic [3:0] data_select,
    output logic hot_reset,
    output logic soft_reset,
    output logic downstream_reset_out_n,
    output logic msi_enable,
    output logic intx_enable,
    output logic [2:0] msi_mult_enable,
    input wire logic msi_req,
    input wire logic [31:0] msi_msg_addr,
    output logic msi_wr_valid,
    output logic [31:0] msi_wr_addr
);
    import spm_pkg::*;

    logic ups_q;
    logic [SPM_DFLT_W-1:0] dflt_q;
    logic [1:0] ps_q;
    logic pme_en_q;
    logic [3:0] dsel_q;
    logic msi_en_q;
    logic [2:0] mme_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic hot_q;
    logic soft_q;
    logic wr_csr_b0;
    logic wr_csr_b1;
    logic wr_msi_b2;
    logic d3_exit;
    logic msi_wv_q;
    logic [31:0] msi_wa_q;

    // true when the address hits the given word and the given byte lane is enabled
    function automatic logic wr_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs,
                                    input logic [3:0] be,
                                    input int lane);
        wr_hit = (addr[7:2] == ofs[7:2]) && be[lane];
    endfunction : wr_hit

    // next pointer of the power management header depends on port role
    function automatic logic [7:0] pm_next(input logic up);
        pm_next = up ? SPM_NEXT_UP : SPM_NEXT_DN;
    endfunction : pm_next

    // read-only defaults, replaceable only by the loader
    spm_dflt_hold u_dflt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(dflt_load),
        .value(dflt_value),
        .dflt_q(dflt_q)
    );

    // port role strap, registered again on every clock edge after reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ups_q <= 1'b0;
        end else begin
            ups_q <= port_is_upstream;
        end
    end

    // write strobes per byte lane
    assign wr_csr_b0 = cfg_req && cfg_wr &&
                       wr_hit(cfg_addr, SPM_OFS_PM_CSR, cfg_be, 0);
    assign wr_csr_b1 = cfg_req && cfg_wr &&
                       wr_hit(cfg_addr, SPM_OFS_PM_CSR, cfg_be, 1);
    assign wr_msi_b2 = cfg_req && cfg_wr && !ups_q &&
                       wr_hit(cfg_addr, SPM_OFS_MSI_CAP, cfg_be, 2);
    // leaving D3hot for D0 by software write
    assign d3_exit = wr_csr_b0 && (ps_q == SPM_D3HOT) &&
                     (cfg_wdata[SPM_PS_HI:SPM_PS_LO] == SPM_D0);

    // power state field
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ps_q <= SPM_D0;
        end else if (wr_csr_b0) begin
            ps_q <= cfg_wdata[SPM_PS_HI:SPM_PS_LO];
        end
    end

    // PME enable and data select; data select cleared by internal reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pme_en_q <= 1'b0;
            dsel_q <= SPM_DSEL_RST;
        end else if (wr_csr_b1) begin
            pme_en_q <= cfg_wdata[SPM_PME_EN];
            dsel_q <= cfg_wdata[SPM_DSEL_HI:SPM_DSEL_LO];
        end else if (soft_q) begin
            dsel_q <= SPM_DSEL_RST;
        end
    end

    // MSI control, only present on downstream ports
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msi_en_q <= 1'b0;
            mme_q <= SPM_MME_RST;
        end else if (wr_msi_b2) begin
            msi_en_q <= cfg_wdata[SPM_MSI_EN];
            mme_q <= cfg_wdata[SPM_MME_HI:SPM_MME_LO];
        end else if (soft_q || ups_q) begin
            msi_en_q <= 1'b0;
            mme_q <= SPM_MME_RST;
        end
    end

    // reset pulses on D3hot to D0; internal reset only without suppression
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hot_q <= 1'b0;
            soft_q <= 1'b0;
        end else begin
            hot_q <= d3_exit;
            soft_q <= d3_exit && !dflt_q[SPM_DF_NSR];
        end
    end

    // read data assembly; reserved bits stay zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (cfg_addr[7:2])
            SPM_OFS_PM_CAP[7:2]: begin
                rdata_d[7:0] = SPM_PM_CAP_ID;
                rdata_d[15:8] = pm_next(ups_q);
                rdata_d[18:16] = SPM_PM_REV;
                rdata_d[19] = 1'b0;
                rdata_d[21] = dflt_q[SPM_DF_DSI];
                rdata_d[24:22] = dflt_q[SPM_DF_AUX_HI:SPM_DF_AUX_LO];
                rdata_d[25] = dflt_q[SPM_DF_D1];
                rdata_d[26] = dflt_q[SPM_DF_D2];
                rdata_d[31:27] =
                    dflt_q[SPM_DF_PMES_HI:SPM_DF_PMES_LO];
            end
            SPM_OFS_PM_CSR[7:2]: begin
                rdata_d[1:0] = ps_q;
                rdata_d[3] = dflt_q[SPM_DF_NSR];
                rdata_d[8] = pme_en_q;
                rdata_d[12:9] = dsel_q;
                rdata_d[14:13] = SPM_DSCALE;
                rdata_d[15] = 1'b0;
                rdata_d[23:22] = 2'b00;
                rdata_d[31:24] =
                    dflt_q[SPM_DF_DATA_HI:SPM_DF_DATA_LO];
            end
            SPM_OFS_MSI_CAP[7:2]: begin
                if (!ups_q) begin
                    rdata_d[7:0] = SPM_MSI_CAP_ID;
                    rdata_d[15:8] = SPM_MSI_NEXT;
                    rdata_d[16] = msi_en_q;
                    rdata_d[19:17] = SPM_MSI_MMC;
                    rdata_d[22:20] = mme_q;
                    rdata_d[23] = SPM_MSI_64BIT;
                end
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // answer one edge after each request, data held until next read request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= cfg_req;
            if (cfg_req && !cfg_wr) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // MSI memory write request to the dword-aligned message address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msi_wv_q <= 1'b0;
            msi_wa_q <= 32'h0000_0000;
        end else begin
            msi_wv_q <= msi_req && msi_en_q && !ups_q;
            if (msi_req && msi_en_q) begin
                msi_wa_q <= {msi_msg_addr[31:2], SPM_ADDR_LSB_ZERO};
            end
        end
    end

    // outputs
    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;
    assign power_state = ps_q;
    assign pme_enable = pme_en_q;
    assign data_select = dsel_q;
    assign hot_reset = hot_q;
    assign soft_reset = soft_q;
    assign downstream_reset_out_n = 1'b1;
    assign msi_enable = msi_en_q;
    assign intx_enable = !msi_en_q;
    assign msi_mult_enable = mme_q;
    assign msi_wr_valid = msi_wv_q;
    assign msi_wr_addr = msi_wa_q;

    // capability ID answered on the next edge
    AST_PM_CAP_ID: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] == SPM_OFS_PM_CAP[7:2])
        |=> (cfg_ack && cfg_rdata[7:0] == 8'h01))
        else $error("pm capability id wrong");

    // next pointer follows the role held when the read was taken
    AST_PM_NEXT: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] == SPM_OFS_PM_CAP[7:2])
        |=> (cfg_rdata[15:8] == ($past(ups_q) ? 8'h5C : 8'h4C)))
        else $error("pm next pointer wrong");

    // revision and legacy bits fixed
    AST_PM_REV: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] == SPM_OFS_PM_CAP[7:2])
        |=> (cfg_rdata[18:16] == 3'b011 && !cfg_rdata[19]
             && !cfg_rdata[20]))
        else $error("pm revision or legacy bit wrong");

    // bridge extension byte legacy bits zero
    AST_EXT_ZERO: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] == SPM_OFS_PM_CSR[7:2])
        |=> (cfg_rdata[23:16] == 8'h00 && !cfg_rdata[15]))
        else $error("extension or pme status not zero");

    // read-only fields mirror loaded defaults, never host data
    AST_RO_DFLT: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] == SPM_OFS_PM_CAP[7:2])
        |=> (cfg_rdata[31:21] == {$past(dflt_q[10:1]), $past(dflt_q[0])}))
        else $error("read-only defaults not reflected");

    // power state takes the written code on the next edge
    AST_PS_WRITE: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_csr_b0 |=> (power_state == $past(cfg_wdata[1:0])))
        else $error("power state not updated");

    // D3hot to D0 gives a hot reset pulse, downstream reset stays off
    AST_HOT_RST: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        d3_exit |=> (hot_reset && downstream_reset_out_n)
        ##1 !hot_reset)
        else $error("hot reset pulse wrong");

    // internal reset only when suppression bit is clear
    AST_SOFT_RST: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        hot_reset |-> (soft_reset == !$past(dflt_q[SPM_DF_NSR])))
        else $error("internal reset gating wrong");

    // PME enable follows a byte one write
    AST_PME_EN: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_csr_b1 |=> (pme_enable == $past(cfg_wdata[8])))
        else $error("pme enable not updated");

    // MSI header on downstream ports
    AST_MSI_HDR: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && !ups_q
         && cfg_addr[7:2] == SPM_OFS_MSI_CAP[7:2])
        |=> (cfg_rdata[15:0] == 16'h6405 && cfg_rdata[23]))
        else $error("msi header wrong");

    // MSI enable and INTx are exclusive
    AST_INTX_OFF: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        msi_enable |-> !intx_enable)
        else $error("intx active with msi enabled");

    // MSI enable takes the written bit of a downstream lane two write
    AST_MSI_EN: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_msi_b2 |=> (msi_enable == $past(cfg_wdata[16])))
        else $error("msi enable not updated");

    // MSI write address is dword aligned copy of message address
    AST_MSI_ADDR: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (msi_req && msi_enable && !ups_q) |=> (msi_wr_valid
        && msi_wr_addr == {$past(msi_msg_addr[31:2]), 2'b00}))
        else $error("msi address wrong");

    // unmapped words read zero
    AST_UNMAPPED: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg_req && !cfg_wr && cfg_addr[7:2] != SPM_OFS_PM_CAP[7:2]
         && cfg_addr[7:2] != SPM_OFS_PM_CSR[7:2]
         && cfg_addr[7:2] != SPM_OFS_MSI_CAP[7:2])
        |=> (cfg_rdata == 32'h0000_0000))
        else $error("unmapped word not zero");
endmodule : spm_cap_regs

// *** tb/spm_cfg_requester.sv ***
// Purpose: configuration requester model facing the capability bank
// Assumes: one pulse per access, answer one edge after the pulse
// Notes: write data lines show inverted junk between accesses
`timescale 1ns/10ps
module spm_cfg_requester (
    input wire logic clk_sys,
    output logic cfg_req,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    // idle values at time zero
    initial begin
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'hFF;
        cfg_be = 4'h0;
        cfg_wdata = 32'hA5A5A5A5;
    end

    // one access: pulse at one edge, take the answer at the next
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic ack, output logic [31:0] rd);
        @(posedge clk_sys);
        #1;
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = wd; // power state codes travel whole in lane 0
        @(posedge clk_sys);
        #1;
        ack = cfg_ack;
        rd = cfg_rdata;
        cfg_req = 1'b0;
        cfg_addr = ~addr;
        cfg_wdata = ~wd; // released address and data lines carry no stale value
    endtask : access
endmodule : spm_cfg_requester

// *** tb/switch_port_pm_msi_capability_tb.sv ***
// Purpose: self-checking bench for the capability bank of one port
// Assumes: requester model drives the config bus, bench drives the rest
// Notes: each scenario task drives and judges before returning
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module switch_port_pm_msi_capability_tb;
    import spm_pkg::*;
    logic clk_sys, rst_n, port_is_upstream, cfg_req, cfg_wr, cfg_ack;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, data_select;
    logic [31:0] cfg_wdata, cfg_rdata, msi_msg_addr, msi_wr_addr, rd;
    logic dflt_load, pme_enable, hot_reset, soft_reset, ack;
    logic downstream_reset_out_n, msi_enable, intx_enable;
    logic msi_req, msi_wr_valid;
    logic [SPM_DFLT_W-1:0] dflt_value;
    logic [1:0] power_state;
    logic [2:0] msi_mult_enable;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    spm_cfg_requester spm_cfg_requester_i (.clk_sys(clk_sys),
        .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata));
    spm_cap_regs spm_cap_regs_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .port_is_upstream(port_is_upstream), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .dflt_load(dflt_load), .dflt_value(dflt_value),
        .power_state(power_state), .pme_enable(pme_enable),
        .data_select(data_select), .hot_reset(hot_reset),
        .soft_reset(soft_reset),
        .downstream_reset_out_n(downstream_reset_out_n),
        .msi_enable(msi_enable), .intx_enable(intx_enable),
        .msi_mult_enable(msi_mult_enable), .msi_req(msi_req),
        .msi_msg_addr(msi_msg_addr), .msi_wr_valid(msi_wr_valid),
        .msi_wr_addr(msi_wr_addr));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard, well above the hundred or so cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            close_out();
        end
    end

    // counts, verdict and end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // read one word and compare it
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        spm_cfg_requester_i.access(1'b0, a, 4'h0, 32'h0, ack, rd);
        `CHK("read ack", 1'b1, ack)
        `CHK("read word", ex, rd)
    endtask : rd_chk

    // write one word, ack expected even when ignored
    task automatic wr_chk(input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd);
        spm_cfg_requester_i.access(1'b1, a, be, wd, ack, rd);
        `CHK("write ack", 1'b1, ack)
    endtask : wr_chk

    // reset values of every word on a downstream port
    task automatic t_reset_vals();
        rd_chk(8'h40, 32'hFFC34C01);
        rd_chk(8'h44, 32'h00000008);
        rd_chk(8'h4C, 32'h00806405);
        rd_chk(8'h48, 32'h00000000);
        `CHK("no downstream reset", 1'b1, downstream_reset_out_n)
        `CHK("intx on", 1'b1, intx_enable)
    endtask : t_reset_vals

    // upstream role: other pointer, no message capability
    task automatic t_upstream();
        @(posedge clk_sys);
        #1;
        port_is_upstream = 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_chk(8'h40, 32'hFFC35C01);
        wr_chk(8'h4C, 4'h4, 32'h00010000);
        rd_chk(8'h4C, 32'h00000000);
        `CHK("upstream msi off", 1'b0, msi_enable)
        @(posedge clk_sys);
        #1;
        port_is_upstream = 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : t_upstream

    // all-ones writes touch only the writable fields
    task automatic t_ro_writes();
        wr_chk(8'h40, 4'hF, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'hFFC34C01);
        wr_chk(8'h44, 4'hF, 32'hFFFFFFFF);
        rd_chk(8'h44, 32'h00001F0B);
        `CHK("pme enable", 1'b1, pme_enable)
        `CHK("data select", 4'hF, data_select)
        wr_chk(8'h4C, 4'hF, 32'hFFFFFFFF);
        rd_chk(8'h4C, 32'h00F16405);
        `CHK("msi on", 1'b1, msi_enable)
        `CHK("intx off", 1'b0, intx_enable)
        `CHK("mult enable", 3'h7, msi_mult_enable)
    endtask : t_ro_writes

    // message writes only while enabled, to an aligned address
    task automatic t_msi();
        logic [31:0] a;
        for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? 32'h12345677 : 32'hFEDCBA9B;
            @(posedge clk_sys);
            #1;
            msi_req = 1'b1;
            msi_msg_addr = a;
            @(posedge clk_sys);
            #1;
            msi_req = 1'b0;
            `CHK("msi valid", (k == 0), msi_wr_valid)
            if (k == 0) begin
                `CHK("msi addr", {a[31:2], 2'b00}, msi_wr_addr)
                wr_chk(8'h4C, 4'h4, 32'h00000000);
                `CHK("msi off", 1'b0, msi_enable)
            end
        end
    endtask : t_msi

    // walk the power states; only D3 to D0 fires a hot reset
    task automatic t_power(input logic nsr);
        logic [1:0] codes [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
        logic [1:0] prev;
        prev = power_state;
        for (int k = 0; k < 5; k++) begin
            wr_chk(8'h44, 4'h1, {30'h0, codes[k]});
            `CHK("power state", codes[k], power_state)
            `CHK("hot reset", prev == 2'h3 && codes[k] == 2'h0,
                hot_reset)
            `CHK("soft reset", prev == 2'h3 && codes[k] == 2'h0 && !nsr,
                soft_reset)
            `CHK("downstream reset", 1'b1, downstream_reset_out_n)
            prev = codes[k];
        end
        @(posedge clk_sys);
        #1;
        `CHK("hot reset end", 1'b0, hot_reset)
    endtask : t_power

    // loader changes read-only defaults; internal reset once cleared
    task automatic t_dflt();
        @(posedge clk_sys);
        #1;
        dflt_load = 1'b1;
        dflt_value = 20'hA5565;
        @(posedge clk_sys);
        #1;
        dflt_load = 1'b0;
        dflt_value = ~dflt_value;
        rd_chk(8'h40, 32'hACA34C01);
        wr_chk(8'h44, 4'hF, 32'h00000000);
        wr_chk(8'h44, 4'h2, 32'h00001F00);
        rd_chk(8'h44, 32'hA5001F00);
        t_power(1'b0);
        `CHK("select cleared", 4'h0, data_select)
        rd_chk(8'h44, 32'hA5000100);
    endtask : t_dflt

    // reset in mid run clears control and restores documented defaults
    task automatic t_mid_reset();
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        #1;
        `CHK("reset pme enable", 1'b0, pme_enable)
        `CHK("reset power state", 2'h0, power_state)
        `CHK("reset hot reset", 1'b0, hot_reset)
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset_vals();
        rd_chk(8'h44, 32'h00000008);
    endtask : t_mid_reset

    // main sequence
    initial begin
        rst_n = 1'b0;
        port_is_upstream = 1'b0;
        dflt_load = 1'b0;
        dflt_value = 20'h0;
        msi_req = 1'b0;
        msi_msg_addr = 32'h0;
        repeat (20) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset_vals();
        t_upstream();
        t_ro_writes();
        t_msi();
        t_power(1'b1);
        t_dflt();
        t_mid_reset();
        close_out();
    end
endmodule : switch_port_pm_msi_capability_tb
